/* File: logic/pma_pkg.sv */
package pma_pkg;
    localparam int NUM_DED = 4;
    localparam int NUM_MC = 64;
    localparam int MC_PER_BLK = 16;
    localparam int NUM_BLK = 4;
    localparam int BLK_IN = 40;
    localparam int NUM_PT = 5;
    localparam int GBUS_W = NUM_DED + 2 * NUM_MC;
    localparam int GBUS_IDX_W = 8;
    localparam int PT_IN = BLK_IN + MC_PER_BLK;
    localparam int SIG_W = 16;
    localparam int MC_IDX_W = 6;

    // fixed control role of each product term when it is not summed
    localparam int PT_XOR = 0;
    localparam int PT_DATA = 1;
    localparam int PT_CLK = 2;
    localparam int PT_RST = 3;
    localparam int PT_SET = 4;
    localparam int PT_OE = 4;

    // dedicated inputs that double as the two output-enable pins
    localparam int OE_PIN_A = 2;
    localparam int OE_PIN_B = 3;

    localparam logic Q_RST = 1'b0;
    localparam logic CLK_PREV_RST = 1'b0;

    typedef enum logic [1:0] {PMA_XOR_LOW, PMA_XOR_HIGH, PMA_XOR_TERM} pma_xor_sel_t;
    typedef enum logic [1:0] {PMA_D_XOR, PMA_D_TERM, PMA_D_PIN} pma_data_sel_t;
    typedef enum logic [2:0] {PMA_FF_D, PMA_FF_T, PMA_FF_JK, PMA_FF_SR, PMA_FF_LATCH} pma_ff_mode_t;
    typedef enum logic [1:0] {PMA_CLK_G0, PMA_CLK_G1, PMA_CLK_G2, PMA_CLK_TERM} pma_clk_src_t;
    typedef enum logic [1:0] {PMA_RST_OFF, PMA_RST_PIN, PMA_RST_TERM, PMA_RST_BOTH} pma_rst_src_t;
    typedef enum logic [2:0] {
        PMA_OE_ON, PMA_OE_OFF, PMA_OE_PIN_A, PMA_OE_PIN_B, PMA_OE_IO, PMA_OE_TERM
    } pma_oe_sel_t;

    typedef struct packed {
        logic [NUM_PT-1:0] alloc;       // 1: term goes to the sum gate
        pma_xor_sel_t xor_sel;
        pma_data_sel_t data_sel;
        pma_ff_mode_t ff_mode;
        pma_clk_src_t clk_src;
        logic ce_en;
        pma_rst_src_t rst_src;
        logic set_en;
        logic [1:0] clear_pin;          // dedicated input used as global clear
        logic out_reg;
        logic fb_reg;
        pma_oe_sel_t oe_sel;
        logic [MC_IDX_W-1:0] oe_io_idx;
        logic [2:0] fold_sel;
        logic casc_en;
    } pma_mc_cfg_t;

    typedef struct packed {
        logic [PT_IN-1:0] true_in;
        logic [PT_IN-1:0] inv_in;
    } pma_pt_mask_t;
endpackage

/* File: logic/pma_switch_matrix.sv */
`timescale 1ns/1ps
module pma_switch_matrix import pma_pkg::*; #(
    parameter int N_OUT = BLK_IN,
    parameter int W_IN = GBUS_W
) (
    input wire logic [W_IN-1:0] gbus,                   // whole global bus
    input wire logic [N_OUT-1:0][GBUS_IDX_W-1:0] sel,   // fixed selection per block input
    output logic [N_OUT-1:0] blk_in                     // chosen block inputs
);
    always_comb begin
        for (int i = 0; i < N_OUT; i++) begin
            // an index past the bus end reads low rather than unknown
            if (int'(sel[i]) < W_IN) begin
                blk_in[i] = gbus[sel[i]];
            end else begin
                blk_in[i] = 1'b0;
            end
        end
    end
endmodule

/* File: logic/pma_macrocell_array.sv */
// Operation
// - dedicated pins serve as input or control
// - global bus holds pins and all feedbacks
// - each block picks forty bus signals
// - five product terms per macrocell
// - allocation mux routes terms sum or control
// - five-term sum, cascade extends further
// - xor second input term, high, low
// - register data from xor, term, pin
// - separate term gives buried registered feedback
// - register acts as D, T, JK, SR
// - latch transparent while clock high
// - clock from global pin or term, rising
// - term clock enable with global clock only
// - reset from clear pin, term, both, none
// - preset from term or none
// - pin and feedback select registered independently
// - output enable mux with six choices
// - disabled pin keeps internal resources usable
// - inverted term foldback onto regional bus
// - foldbacks combine into wide sum terms
// - signature readable regardless of security fuse
// - fuse blocks configuration readback only
`timescale 1ns/1ps
module pma_macrocell_array import pma_pkg::*; #(
    parameter int N_BLK = NUM_BLK,
    parameter int N_MC_BLK = MC_PER_BLK
) (
    input wire logic sys_clk,                                   // system clock, 40 MHz
    input wire logic rst,                                       // synchronous reset, high
    input wire logic [NUM_DED-1:0] ded_in,                      // dedicated input pins
    input wire logic [NUM_MC-1:0] io_in,                        // level seen on each io pin
    output logic [NUM_MC-1:0] io_out,                           // value driven on io pins
    output logic [NUM_MC-1:0] io_oe,                            // high while pin is driven
    input wire pma_mc_cfg_t [NUM_MC-1:0] mc_cfg,                // per-macrocell configuration
    input wire logic [NUM_BLK-1:0][BLK_IN-1:0][GBUS_IDX_W-1:0] sw_sel, // switch picks
    input wire pma_pt_mask_t [NUM_MC-1:0][NUM_PT-1:0] pt_mask,  // and-array connections
    input wire logic [SIG_W-1:0] user_sig,                      // stored user signature
    input wire logic secure_fuse,                               // security fuse programmed
    input wire logic rb_req,                                    // configuration readback request
    input wire logic [MC_IDX_W-1:0] rb_addr,                    // macrocell to read back
    output logic rb_valid,                                      // readback answer strobe
    output pma_mc_cfg_t rb_data,                                // read back configuration
    output logic rb_blocked,                                    // readback refused by fuse
    output logic [SIG_W-1:0] sig_out,                           // signature, always readable
    output logic [NUM_MC-1:0] mc_state                          // storage element states
);
    logic [NUM_MC-1:0] fb;
    logic [NUM_MC-1:0] fold;
    logic [NUM_MC-1:0] casc;
    logic [GBUS_W-1:0] gbus;

    // dedicated pins enter the bus as plain inputs and stay usable as controls
    assign gbus = {fb, io_in, ded_in};

    // an empty term reads low: unused terms are off, not stuck high
    function automatic logic pt_eval(input pma_pt_mask_t mask, input logic [PT_IN-1:0] in_v);
        logic used;
        used = |{mask.true_in, mask.inv_in};
        return used & (&(in_v | ~mask.true_in)) & (&(~in_v | ~mask.inv_in));
    endfunction

    function automatic logic ff_next(input pma_ff_mode_t mode, input logic q,
                                     input logic d, input logic k);
        logic nq;
        nq = q;
        unique case (mode)
            PMA_FF_D: nq = d;
            PMA_FF_T: nq = q ^ d;
            PMA_FF_JK: nq = (d & ~q) | (~k & q);
            PMA_FF_SR: nq = d ? 1'b1 : (k ? 1'b0 : q);
            PMA_FF_LATCH: nq = q;
            default: nq = q;
        endcase
        return nq;
    endfunction

    for (genvar b = 0; b < N_BLK; b++) begin : g_blk
        logic [BLK_IN-1:0] blk_in;

        pma_switch_matrix #(
            .N_OUT(BLK_IN),
            .W_IN(GBUS_W)
        ) u_switch (
            .gbus(gbus),
            .sel(sw_sel[b]),
            .blk_in(blk_in)
        );

        for (genvar m = 0; m < N_MC_BLK; m++) begin : g_mc
            localparam int I = b * N_MC_BLK + m;
            pma_mc_cfg_t cfg;
            logic [PT_IN-1:0] pt_in;
            logic [NUM_PT-1:0] pt;
            logic [NUM_PT-1:0] ctl;
            logic casc_in;
            logic sum;
            logic xor_b;
            logic xor_out;
            logic d_in;
            logic clk_lvl;
            logic clk_prev;
            logic clk_rise;
            logic clk_en;
            logic rst_act;
            logic set_act;
            logic q;
            logic q_eff;
            logic is_latch;

            assign cfg = mc_cfg[I];
            // regional bus is the block's foldbacks beside the switch outputs
            assign pt_in = {fold[b*N_MC_BLK +: N_MC_BLK], blk_in};

            always_comb begin
                for (int k = 0; k < NUM_PT; k++) begin
                    pt[k] = pt_eval(pt_mask[I][k], pt_in);
                    // a term feeds its control role only when not summed
                    ctl[k] = pt[k] & ~cfg.alloc[k];
                end
            end

            if (m == 0) begin : g_head
                assign casc_in = 1'b0;
            end else begin : g_link
                assign casc_in = cfg.casc_en & casc[I-1];
            end

            assign sum = (|(pt & cfg.alloc)) | casc_in;
            assign casc[I] = sum;

            always_comb begin
                unique case (cfg.xor_sel)
                    PMA_XOR_LOW: xor_b = 1'b0;
                    PMA_XOR_HIGH: xor_b = 1'b1;
                    PMA_XOR_TERM: xor_b = ctl[PT_XOR];
                    default: xor_b = 1'b0;
                endcase
            end
            assign xor_out = sum ^ xor_b;

            always_comb begin
                unique case (cfg.data_sel)
                    PMA_D_XOR: d_in = xor_out;
                    PMA_D_TERM: d_in = ctl[PT_DATA];
                    PMA_D_PIN: d_in = io_in[I];
                    default: d_in = xor_out;
                endcase
            end

            always_comb begin
                unique case (cfg.clk_src)
                    PMA_CLK_G0: clk_lvl = ded_in[0];
                    PMA_CLK_G1: clk_lvl = ded_in[1];
                    PMA_CLK_G2: clk_lvl = ded_in[2];
                    PMA_CLK_TERM: clk_lvl = ctl[PT_CLK];
                endcase
            end

            // the selected clock is sampled, so it must stay below half of sys_clk
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    clk_prev <= CLK_PREV_RST;
                end else begin
                    clk_prev <= clk_lvl;
                end
            end
            assign clk_rise = clk_lvl & ~clk_prev;

            // the enable term is ignored when the term itself is the clock
            assign clk_en = (cfg.clk_src != PMA_CLK_TERM && cfg.ce_en) ?
                            ctl[PT_CLK] : 1'b1;

            always_comb begin
                unique case (cfg.rst_src)
                    PMA_RST_OFF: rst_act = 1'b0;
                    PMA_RST_PIN: rst_act = ded_in[cfg.clear_pin];
                    PMA_RST_TERM: rst_act = ctl[PT_RST];
                    PMA_RST_BOTH: rst_act = ded_in[cfg.clear_pin] | ctl[PT_RST];
                endcase
            end
            assign set_act = cfg.set_en & ctl[PT_SET];
            assign is_latch = (cfg.ff_mode == PMA_FF_LATCH);

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    q <= Q_RST;
                end else if (rst_act) begin
                    q <= 1'b0;
                end else if (set_act) begin
                    q <= 1'b1;
                end else if (is_latch) begin
                    if (clk_lvl) begin
                        q <= d_in;
                    end
                end else if (clk_rise && clk_en) begin
                    q <= ff_next(cfg.ff_mode, q, d_in, ctl[PT_DATA]);
                end
            end

            // reset and preset reach the output at once, without waiting for an edge
            always_comb begin
                if (rst_act) begin
                    q_eff = 1'b0;
                end else if (set_act) begin
                    q_eff = 1'b1;
                end else if (is_latch && clk_lvl) begin
                    q_eff = d_in;
                end else begin
                    q_eff = q;
                end
            end

            assign io_out[I] = cfg.out_reg ? q_eff : xor_out;
            // independent of the pin choice, so a term-fed register stays buried
            assign fb[I] = cfg.fb_reg ? q_eff : xor_out;
            assign mc_state[I] = q;

            always_comb begin
                unique case (cfg.oe_sel)
                    PMA_OE_ON: io_oe[I] = 1'b1;
                    PMA_OE_OFF: io_oe[I] = 1'b0;
                    PMA_OE_PIN_A: io_oe[I] = ded_in[OE_PIN_A];
                    PMA_OE_PIN_B: io_oe[I] = ded_in[OE_PIN_B];
                    PMA_OE_IO: io_oe[I] = io_in[cfg.oe_io_idx];
                    PMA_OE_TERM: io_oe[I] = ctl[PT_OE];
                    default: io_oe[I] = 1'b0;
                endcase
            end

            // foldback taps the raw term so it works even when that term is summed
            always_comb begin
                if (int'(cfg.fold_sel) < NUM_PT) begin
                    fold[I] = ~pt[cfg.fold_sel];
                end else begin
                    fold[I] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sig_out <= '0;
        end else begin
            sig_out <= user_sig;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rb_valid <= 1'b0;
            rb_blocked <= 1'b0;
            rb_data <= '0;
        end else begin
            rb_valid <= rb_req;
            if (rb_req) begin
                rb_blocked <= secure_fuse;
                rb_data <= secure_fuse ? pma_mc_cfg_t'('0) : mc_cfg[rb_addr];
            end
        end
    end
endmodule

/* File: bench/pma_macrocell_array_sva.sv */
`timescale 1ns/1ps
module pma_macrocell_array_sva import pma_pkg::*; #(
    parameter int N_BLK = NUM_BLK,
    parameter int N_MC_BLK = MC_PER_BLK
) (
    input wire logic sys_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic [NUM_DED-1:0] ded_in, // dedicated pins
    input wire logic [NUM_MC-1:0] io_out, // pin values
    input wire logic [NUM_MC-1:0] io_oe, // pin enables
    input wire pma_mc_cfg_t [NUM_MC-1:0] mc_cfg, // configuration
    input wire logic [SIG_W-1:0] user_sig, // stored signature
    input wire logic secure_fuse, // security fuse
    input wire logic rb_req, // readback request
    input wire logic [MC_IDX_W-1:0] rb_addr, // readback address
    input wire logic rb_valid, // readback strobe
    input wire pma_mc_cfg_t rb_data, // readback word
    input wire logic rb_blocked, // readback refused
    input wire logic [SIG_W-1:0] sig_out // signature copy
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence open_req_s;
        rb_req && !secure_fuse;
    endsequence
    sequence open_ans_s;
        rb_valid && !rb_blocked;
    endsequence
    // mc_cfg is static while reading, so the current word stands for the requested one
    rb_answer_a: assert property (rb_req |=> rb_valid)
        else $error("readback answer missing");
    rb_pulse_a: assert property (!rb_req |=> !rb_valid)
        else $error("readback strobe without request");
    fuse_block_a: assert property (rb_req && secure_fuse |=> rb_blocked && rb_data == '0)
        else $error("readback not blocked by fuse");
    open_read_a: assert property (open_req_s |=> open_ans_s ##0 (rb_data == mc_cfg[$past(rb_addr)]))
        else $error("readback word wrong");
    data_hold_a: assert property (!rb_req |=> $stable(rb_data) && $stable(rb_blocked))
        else $error("readback answer not held");
    sig_follow_a: assert property (!$past(rst) |-> sig_out == $past(user_sig))
        else $error("signature not readable");
    oe_fixed_a: assert property (mc_cfg[0].oe_sel inside {PMA_OE_ON, PMA_OE_OFF}
        |-> io_oe[0] == (mc_cfg[0].oe_sel == PMA_OE_ON)) else $error("fixed enable wrong");
    oe_pin_a: assert property (mc_cfg[0].oe_sel == PMA_OE_PIN_B |-> io_oe[0] == ded_in[OE_PIN_B])
        else $error("enable pin not followed");
    reset_wins_a: assert property (mc_cfg[0].out_reg && mc_cfg[0].rst_src == PMA_RST_PIN
        && ded_in[mc_cfg[0].clear_pin] |-> !io_out[0]) else $error("clear did not win");
endmodule
bind pma_macrocell_array pma_macrocell_array_sva #(.N_BLK(N_BLK), .N_MC_BLK(N_MC_BLK)) u_sva (
    .sys_clk(sys_clk), .rst(rst), .ded_in(ded_in), .io_out(io_out), .io_oe(io_oe),
    .mc_cfg(mc_cfg), .user_sig(user_sig), .secure_fuse(secure_fuse), .rb_req(rb_req),
    .rb_addr(rb_addr), .rb_valid(rb_valid), .rb_data(rb_data), .rb_blocked(rb_blocked),
    .sig_out(sig_out)
);

/* File: bench/pma_pin_model.sv */
`timescale 1ns/1ps
module pma_pin_model import pma_pkg::*; (
    input wire logic [NUM_MC-1:0] io_out, // values the array drives
    input wire logic [NUM_MC-1:0] io_oe, // array drive enables
    input wire logic [NUM_MC-1:0] ext_io, // levels the outside drives
    output logic [NUM_MC-1:0] io_in // resolved pin levels
);
    // outside drivers step back wherever the array drives; contention not modelled
    assign io_in = (io_oe & io_out) | (~io_oe & ext_io);
endmodule

/* File: bench/pma_macrocell_array_bench.sv */
`timescale 1ns/1ps
module pma_macrocell_array_bench;
    import pma_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [NUM_DED-1:0] ded_in = '0;
    logic [NUM_MC-1:0] io_in, io_out, io_oe, mc_state;
    logic [NUM_MC-1:0] ext_io = '0;
    pma_mc_cfg_t [NUM_MC-1:0] mc_cfg;
    logic [NUM_BLK-1:0][BLK_IN-1:0][GBUS_IDX_W-1:0] sw_sel = '1;
    pma_pt_mask_t [NUM_MC-1:0][NUM_PT-1:0] pt_mask = '0;
    logic [SIG_W-1:0] user_sig = '0;
    logic secure_fuse = 1'b0;
    logic rb_req = 1'b0;
    logic [MC_IDX_W-1:0] rb_addr = '0;
    logic rb_valid, rb_blocked;
    logic [SIG_W-1:0] sig_out;
    pma_mc_cfg_t rb_data, c;
    int seed = 28;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic q, d, v, kk;
    always #12.5 sys_clk = ~sys_clk;
    pma_macrocell_array u_pma_macrocell_array (.sys_clk(sys_clk), .rst(rst), .ded_in(ded_in),
        .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .mc_cfg(mc_cfg), .sw_sel(sw_sel),
        .pt_mask(pt_mask), .user_sig(user_sig), .secure_fuse(secure_fuse), .rb_req(rb_req),
        .rb_addr(rb_addr), .rb_valid(rb_valid), .rb_data(rb_data), .rb_blocked(rb_blocked),
        .sig_out(sig_out), .mc_state(mc_state));
    pma_pin_model u_pma_pin_model (.io_out(io_out), .io_oe(io_oe), .ext_io(ext_io), .io_in(io_in));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // sum of mc0: ded_in[3] or pin 1, the only terms allocated to the or gate
    task automatic new_data();
        ded_in[3] = 1'($random(seed));
        ext_io[1] = 1'($random(seed));
        d = ded_in[3] | ext_io[1];
    endtask
    function automatic logic oe_exp(input int i);
        case (i)
            0: return 1'b1;
            1: return 1'b0;
            2: return ded_in[OE_PIN_A];
            3: return ded_in[OE_PIN_B];
            default: return ext_io[1];
        endcase
    endfunction
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        c = '0;
        c.oe_sel = PMA_OE_OFF;
        mc_cfg = {NUM_MC{c}};
        for (int k = 0; k < 5; k++) sw_sel[0][k] = GBUS_IDX_W'(k == 4 ? 5 : k);
        for (int k = 2; k < 5; k++) pt_mask[0][k].true_in[k] = 1'b1;
        // pt1 follows ded_in[0], the K or R input of the jk and sr modes
        pt_mask[0][1].true_in[0] = 1'b1;
        c.alloc = 5'h18;
        c.oe_sel = PMA_OE_ON;
        c.clk_src = PMA_CLK_G1;
        c.oe_io_idx = 6'h01;
        mc_cfg[0] = c;
        q = 1'b0;
        step(5);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            mc_cfg[0].xor_sel = i[0] ? PMA_XOR_HIGH : PMA_XOR_LOW;
            new_data();
            step(1);
            check(io_out[0], d ^ i[0]);
        end
        mc_cfg[0].xor_sel = PMA_XOR_LOW;
        mc_cfg[0].out_reg = 1'b1;
        for (int i = 0; i < 24; i++) begin
            mc_cfg[0].ff_mode = i < 8 ? PMA_FF_D : PMA_FF_T;
            mc_cfg[0].ce_en = i >= 16;
            v = 1'($random(seed));
            ded_in[2] = v;
            new_data();
            ded_in[1] = 1'b0;
            step(2);
            ded_in[1] = 1'b1;
            step(2);
            if (i < 16 || v) q = i < 8 ? d : q ^ d;
            check(mc_state[0], q);
            check(io_out[0], q);
        end
        mc_cfg[0].ce_en = 1'b0;
        for (int i = 0; i < 8; i++) begin
            mc_cfg[0].ff_mode = i < 4 ? PMA_FF_JK : PMA_FF_SR;
            new_data();
            ded_in[0] = 1'($random(seed));
            kk = ded_in[0];
            ded_in[1] = 1'b0;
            step(2);
            ded_in[1] = 1'b1;
            step(2);
            if (i < 4) q = (d & ~q) | (~kk & q);
            else q = d ? 1'b1 : (kk ? 1'b0 : q);
            check(mc_state[0], q);
        end
        mc_cfg[0].ff_mode = PMA_FF_LATCH;
        for (int i = 0; i < 8; i++) begin
            ded_in[1] = i[0];
            new_data();
            step(1);
            if (i[0]) q = d;
            check(io_out[0], q);
        end
        mc_cfg[0].alloc = 5'h08;
        mc_cfg[0].rst_src = PMA_RST_PIN;
        mc_cfg[0].clear_pin = 2'h3;
        mc_cfg[0].set_en = 1'b1;
        ext_io[1] = 1'b1;
        for (int i = 0; i < 2; i++) begin
            ded_in[3] = !i[0];
            step(1);
            check(io_out[0], i[0]);
        end
        for (int i = 0; i < 12; i++) begin
            mc_cfg[0].oe_sel = pma_oe_sel_t'(i % 6);
            ded_in = 4'($random(seed));
            ext_io = {$random(seed), $random(seed)};
            step(1);
            check(io_oe[0], oe_exp(i % 6));
        end
        step(1);
        for (int i = 0; i < 16; i++) begin
            rb_req = 1'b1;
            rb_addr = i[0] ? 6'h00 : 6'($random(seed));
            secure_fuse = 1'($random(seed));
            user_sig = 16'($random(seed));
            step(1);
            check(rb_valid, 1'b1);
            check(rb_blocked, secure_fuse);
            check(rb_data, secure_fuse ? '0 : mc_cfg[rb_addr]);
            check(sig_out, user_sig);
        end
        rb_req = 1'b0;
        step(1);
        check(rb_valid, 1'b0);
        give_verdict();
    end
endmodule
